/* hdl/cpu_interrupt_response.sv */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "cpu_int_consts.svh"

// Function
// - nonmaskable request accepted regardless of enable flags
// - nonmaskable: discard next fetch, restart to 0066H
// - restart pushes program counter, jumps page zero
// - software selects maskable mode 0, 1, 2
// - mode 0 executes device supplied instruction
// - mode 0 also takes multi-byte device instructions
// - two automatic waits in every acknowledge cycle
// - reset selects maskable mode 0
// - mode 1 restarts to 0038H with waits
// - mode 2 pointer: page high, vector low
// - reset clears the vector page register
// - table read: low byte, then high byte
// - mode 2 pushes counter, reads table, jumps
// - mode 2 takes 19 clocks: 7+6+6
// - non-fetch reads get extra access time
// - refresh row address on address lines 0-6
// - maskable accept clears both enable flags
// - nonmaskable accept clears only accept flag
// - enable instruction delays acceptance one instruction
// - nonmaskable return copies saved flag back
module cpu_interrupt_response
    import cpu_int_pkg::*;
#(
    parameter int AUTO_WAITS = `ACK_AUTO_WAITS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire pin_in_t pins,
    output mem_bus_t bus,
    input wire logic instr_done,
    input wire logic instr_ei,
    input wire logic instr_di,
    input wire logic instr_return_from_nonmaskable,
    input wire logic operand_req,
    input wire logic [15:0] pc,
    input wire logic [15:0] sp,
    output logic busy,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic sp_load,
    output logic [15:0] sp_value,
    output logic inject_valid,
    output logic [7:0] inject_byte,
    output logic device_operands,
    output logic accept_enable_flag,
    output logic saved_enable_flag
);

    generate
        if (AUTO_WAITS < 1 || AUTO_WAITS > 3) begin : g_bad_waits
            $error("AUTO_WAITS must lie in 1..3");
        end
    endgenerate

    localparam logic [1:0] WAITS = AUTO_WAITS[1:0];
    // data bus released while in reset: nothing may be driven then
    localparam mem_bus_t BUS_IDLE = '{dout_oe_n: 1'b1, default: '0};

    // pin synchronisers: stage one feeds stage two only
    pin_in_t pin_s1;
    pin_in_t pin_s2;
    logic nmi_prev_n;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            nmi_prev_n <= 1'b1;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            nmi_prev_n <= pin_s2.nmi_req_n;
        end
    end

    // state
    seq_state_t state;
    seq_state_t next_state;
    tstate_t tst;
    tstate_t next_tst;
    logic [1:0] auto_cnt;
    logic [1:0] next_auto_cnt;
    int_mode_t mode;
    logic [7:0] vpage;
    logic [6:0] refresh_cnt;
    logic nmi_pending;
    logic serving_nmi;
    logic [7:0] vec_byte;
    logic [7:0] tab_lo;

    // decode
    wire nmi_edge = nmi_prev_n & ~pin_s2.nmi_req_n;
    wire idle = (state == st_idle);
    wire take_nmi = idle & instr_done & nmi_pending;
    // the enable instruction's own boundary never accepts
    wire int_ok = accept_enable_flag & ~instr_ei & ~instr_di;
    wire take_int = idle & instr_done & ~nmi_pending & ~pin_s2.int_req_n & int_ok;
    wire take_opnd = idle & ~instr_done & device_operands & operand_req;
    wire is_m1 = (state == st_fetch) | (state == st_ack);
    wire is_ack = (state == st_ack) | (state == st_operand);
    wire is_rd = (state == st_tab_lo) | (state == st_tab_hi);
    wire waiting = ~pin_s2.wait_n;
    wire need_auto = is_ack & (auto_cnt != WAITS);
    wire end_of_t2 = ((tst == t_two) | (tst == t_wait)) & ~need_auto & ~waiting;
    wire cycle_last = (state == st_internal) | (is_m1 & (tst == t_four))
        | (~is_m1 & ~idle & (tst == t_three));
    // fetch-type reads latch at the end of T2; table reads hold one more clock
    wire cap_early = (is_ack | (state == st_fetch)) & end_of_t2;
    wire cap_late = is_rd & (tst == t_three);
    wire [15:0] sp_dec1 = sp - 16'h0001;
    wire [15:0] sp_dec2 = sp - 16'h0002;
    wire [15:0] tab_ptr = {vpage, vec_byte};
    wire [15:0] tab_ptr1 = tab_ptr + 16'h0001;
    wire mode2_call = ~serving_nmi & (mode == mode_vector_table);
    wire ack_to_inject = (state == st_ack) & cycle_last & (mode == mode_device_instr);
    wire call_done = cycle_last & (((state == st_push_lo) & ~mode2_call)
        | (state == st_tab_hi));

    // sequencer
    always_comb begin
        next_state = state;
        next_tst = tst;
        next_auto_cnt = auto_cnt;
        if (idle) begin
            next_tst = t_one;
            next_auto_cnt = 2'h0;
            if (take_nmi) begin
                next_state = st_fetch;
            end else if (take_int) begin
                next_state = st_ack;
            end else if (take_opnd) begin
                next_state = st_operand;
            end
        end else if (cycle_last) begin
            next_tst = t_one;
            next_auto_cnt = 2'h0;
            case (state)
                st_fetch: next_state = st_internal;
                st_ack: next_state = (mode == mode_device_instr) ? st_idle : st_internal;
                st_internal: next_state = st_push_hi;
                st_push_hi: next_state = st_push_lo;
                st_push_lo: next_state = mode2_call ? st_tab_lo : st_idle;
                st_tab_lo: next_state = st_tab_hi;
                default: next_state = st_idle;
            endcase
        end else begin
            case (tst)
                t_one: next_tst = t_two;
                t_two, t_wait: begin
                    if (need_auto) begin
                        next_tst = t_wait;
                        next_auto_cnt = auto_cnt + 2'h1;
                    end else if (waiting) begin
                        next_tst = t_wait;
                    end else begin
                        next_tst = t_three;
                    end
                end
                t_three: next_tst = t_four;
                default: next_tst = t_one;
            endcase
        end
    end

    // bus strobes for a given state and clock within the cycle
    function automatic mem_bus_t drive(input seq_state_t s, input tstate_t t);
        mem_bus_t b;
        logic early;
        logic late;
        b = '0;
        b.dout_oe_n = 1'b1;
        early = (t == t_one) | (t == t_two) | (t == t_wait);
        late = (t == t_three) | (t == t_four);
        case (s)
            st_fetch, st_ack: begin
                b.opcode_fetch_cycle = early;
                b.addr = pc;
                if (late) begin
                    b.addr = {vpage, 1'b0, refresh_cnt};
                    b.refresh = 1'b1;
                    b.mem_req = (t == t_three);
                end else if (s == st_fetch) begin
                    b.mem_req = 1'b1;
                    b.rd = 1'b1;
                end else begin
                    b.io_ack = (t != t_one);
                end
            end
            st_operand: begin
                b.addr = pc;
                b.io_ack = (t != t_one);
            end
            st_push_hi, st_push_lo: begin
                b.addr = (s == st_push_hi) ? sp_dec1 : sp_dec2;
                b.dout = (s == st_push_hi) ? pc[15:8] : pc[7:0];
                b.dout_oe_n = 1'b0;
                b.mem_req = 1'b1;
                b.wr = (t != t_one);
            end
            st_tab_lo, st_tab_hi: begin
                b.addr = (s == st_tab_lo) ? tab_ptr : tab_ptr1;
                b.mem_req = 1'b1;
                b.rd = 1'b1;
            end
            default: b.addr = 16'h0000;
        endcase
        return b;
    endfunction

    // a process, so changes of pc, sp, page and row inside the function wake it
    mem_bus_t next_bus;
    always_comb next_bus = drive(next_state, next_tst);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= st_idle;
            tst <= t_one;
            auto_cnt <= 2'h0;
            bus <= BUS_IDLE;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            tst <= next_tst;
            auto_cnt <= next_auto_cnt;
            bus <= next_bus;
            busy <= (next_state != st_idle);
        end
    end

    // captured bytes; the vector byte is used as supplied by the device
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vec_byte <= 8'h00;
            tab_lo <= 8'h00;
        end else begin
            if (cap_early & (state == st_ack)) begin
                vec_byte <= pin_s2.din;
            end
            if (cap_late & (state == st_tab_lo)) begin
                tab_lo <= pin_s2.din;
            end
        end
    end

    // refresh row advances once per opcode-type cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            refresh_cnt <= `RST_REFRESH;
        end else if (is_m1 & cycle_last) begin
            refresh_cnt <= refresh_cnt + 7'h01;
        end
    end

    // enable flags and the pending nonmaskable latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accept_enable_flag <= 1'b0;
            saved_enable_flag <= 1'b0;
            nmi_pending <= 1'b0;
            serving_nmi <= 1'b0;
        end else begin
            if (instr_done & instr_ei) begin
                accept_enable_flag <= 1'b1;
                saved_enable_flag <= 1'b1;
            end else if (instr_done & instr_di) begin
                accept_enable_flag <= 1'b0;
                saved_enable_flag <= 1'b0;
            end else if (instr_done & instr_return_from_nonmaskable) begin
                accept_enable_flag <= saved_enable_flag;
            end
            if (take_nmi) begin
                accept_enable_flag <= 1'b0;
                serving_nmi <= 1'b1;
            end else if (take_int) begin
                accept_enable_flag <= 1'b0;
                saved_enable_flag <= 1'b0;
                serving_nmi <= 1'b0;
            end
            // a new edge in the accepting cycle stays pending
            nmi_pending <= nmi_edge | (nmi_pending & ~take_nmi);
        end
    end

    // results handed to the core
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_load <= 1'b0;
            pc_value <= 16'h0000;
            sp_load <= 1'b0;
            sp_value <= 16'h0000;
            inject_valid <= 1'b0;
            inject_byte <= 8'h00;
            device_operands <= 1'b0;
        end else begin
            pc_load <= call_done;
            sp_load <= call_done;
            sp_value <= sp_dec2;
            if (call_done) begin
                if (serving_nmi) begin
                    pc_value <= `NMI_TARGET;
                end else if (mode == mode_fixed_restart) begin
                    pc_value <= `MODE1_TARGET;
                end else begin
                    pc_value <= {pin_s2.din, tab_lo};
                end
            end
            inject_valid <= ack_to_inject | ((state == st_operand) & cycle_last);
            if (cap_early & is_ack) begin
                inject_byte <= pin_s2.din;
            end
            // operand bytes of a device instruction come from the device too
            if (ack_to_inject) begin
                device_operands <= 1'b1;
            end else if (instr_done) begin
                device_operands <= 1'b0;
            end
        end
    end

    // register port
    wire wr_ctrl = reg_wr & (reg_addr == `REG_CTRL);
    wire wr_vpage = reg_wr & (reg_addr == `REG_VPAGE);
    wire [1:0] wr_mode = reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire [7:0] status_word = {busy, nmi_pending, serving_nmi, device_operands,
        saved_enable_flag, accept_enable_flag, mode};
    wire [7:0] read_mux = (reg_addr == `REG_CTRL) ? {6'h00, mode}
        : (reg_addr == `REG_VPAGE) ? vpage
        : (reg_addr == `REG_STATUS) ? status_word
        : {1'b0, refresh_cnt};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode <= int_mode_t'(`RST_MODE);
            vpage <= `RST_VPAGE;
            reg_rdata <= 8'h00;
        end else begin
            // the unused mode code is ignored so the mode stays valid
            if (wr_ctrl & (wr_mode != 2'b11)) begin
                mode <= int_mode_t'(wr_mode);
            end
            if (wr_vpage) begin
                vpage <= reg_wdata;
            end
            reg_rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

endmodule // cpu_interrupt_response

/* hdl/cpu_int_consts.svh */
`ifndef CPU_INT_CONSTS_SVH
`define CPU_INT_CONSTS_SVH

// register offsets on the plain register port
`define REG_CTRL 2'h0
`define REG_VPAGE 2'h1
`define REG_STATUS 2'h2
`define REG_REFRESH 2'h3

// field positions
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1

// reset values
`define RST_MODE 2'h0
`define RST_VPAGE 8'h00
`define RST_REFRESH 7'h00

// restart targets
`define NMI_TARGET 16'h0066
`define MODE1_TARGET 16'h0038

// automatic wait states in every acknowledge cycle
`define ACK_AUTO_WAITS 2

`endif

/* hdl/cpu_int_pkg.sv */
package cpu_int_pkg;

    typedef enum logic [1:0] {
        mode_device_instr = 2'b00,
        mode_fixed_restart = 2'b01,
        mode_vector_table = 2'b10
    } int_mode_t;

    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_fetch = 4'b0001,
        st_ack = 4'b0010,
        st_internal = 4'b0011,
        st_push_hi = 4'b0100,
        st_push_lo = 4'b0101,
        st_tab_lo = 4'b0110,
        st_tab_hi = 4'b0111,
        st_operand = 4'b1000
    } seq_state_t;

    typedef enum logic [2:0] {
        t_one = 3'b000,
        t_two = 3'b001,
        t_wait = 3'b010,
        t_three = 3'b011,
        t_four = 3'b100
    } tstate_t;

    // memory and acknowledge strobes, all active high except the enable
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] dout;
        logic dout_oe_n;
        logic mem_req;
        logic rd;
        logic wr;
        logic io_ack;
        logic opcode_fetch_cycle;
        logic refresh;
    } mem_bus_t;

    // raw pin levels, asynchronous to sys_clk
    typedef struct packed {
        logic nmi_req_n;
        logic int_req_n;
        logic wait_n;
        logic [7:0] din;
    } pin_in_t;

endpackage

/* verif/cpu_int_monitor.sv */
`timescale 1ns/1ns
`include "cpu_int_consts.svh"
module cpu_int_monitor
    import cpu_int_pkg::*;
#(
    parameter int AUTO_WAITS = `ACK_AUTO_WAITS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire mem_bus_t bus,
    input wire logic [15:0] sp,
    input wire logic busy,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic sp_load,
    input wire logic [15:0] sp_value,
    input wire logic inject_valid,
    input wire logic accept_enable_flag,
    input wire logic saved_enable_flag
);
    logic [1:0] mode_q;
    logic [6:0] row_q;
    logic [5:0] bcnt;
    logic [3:0] acnt;
    logic ack_seen, ref_q, has_row;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a refused mode 3 write must leave the shadow mode alone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {mode_q, row_q, bcnt, acnt, ack_seen, ref_q, has_row} <= '0;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[1:0] != 2'h3)
                mode_q <= reg_wdata[1:0];
            if (bus.refresh && !ref_q)
                row_q <= bus.addr[6:0];
            if (bus.refresh && !ref_q)
                has_row <= 1'b1;
            ref_q <= bus.refresh;
            ack_seen <= busy && (ack_seen || bus.io_ack);
            bcnt <= busy ? bcnt + 6'd1 : 6'd0;
            acnt <= bus.io_ack ? acnt + 4'd1 : 4'd0;
        end
    end
    property p_sp_push;
        pc_load |-> sp_load && sp_value == sp - 16'h0002;
    endproperty
    a_sp_push: assert property (p_sp_push) else $error("sp not lowered by 2");
    property p_mode2_len;
        $fell(busy) && ack_seen && mode_q == 2'h2 |-> bcnt == 6'd19;
    endproperty
    a_mode2_len: assert property (p_mode2_len) else $error("table call length");
    property p_mode1_target;
        $fell(busy) && ack_seen && mode_q == 2'h1 |-> pc_load && pc_value == `MODE1_TARGET;
    endproperty
    a_mode1_target: assert property (p_mode1_target) else $error("mode 1 target");
    property p_nmi_target;
        $fell(busy) && !ack_seen |-> pc_load && pc_value == `NMI_TARGET && !accept_enable_flag;
    endproperty
    a_nmi_target: assert property (p_nmi_target) else $error("nmi target");
    property p_mode0_inject;
        $fell(busy) && ack_seen && mode_q == 2'h0 |-> !pc_load ##[0:2] inject_valid;
    endproperty
    a_mode0_inject: assert property (p_mode0_inject) else $error("no injected byte");
    property p_ack_waits;
        $fell(bus.io_ack) |-> acnt > AUTO_WAITS;
    endproperty
    a_ack_waits: assert property (p_ack_waits) else $error("acknowledge too short");
    property p_accept_clears;
        $rose(bus.io_ack) && busy |-> !accept_enable_flag && !saved_enable_flag;
    endproperty
    a_accept_clears: assert property (p_accept_clears) else $error("flags kept");
    property p_refresh_row;
        $rose(bus.refresh) && has_row |-> bus.addr[6:0] == row_q + 7'h01 && !bus.addr[7];
    endproperty
    a_refresh_row: assert property (p_refresh_row) else $error("refresh row");
    c_mode2: cover property ($fell(busy) && ack_seen && mode_q == 2'h2);
    c_nmi: cover property ($fell(busy) && !ack_seen);
    c_inject: cover property (inject_valid && !busy);
endmodule // cpu_int_monitor
bind cpu_interrupt_response cpu_int_monitor #(.AUTO_WAITS(AUTO_WAITS)) u_monitor (.sys_clk,
    .rst, .reg_addr, .reg_wdata, .reg_wr, .bus, .sp, .busy, .pc_load, .pc_value, .sp_load,
    .sp_value, .inject_valid, .accept_enable_flag, .saved_enable_flag);

/* verif/int_partner.sv */
`timescale 1ns/1ns
module int_partner
    import cpu_int_pkg::*;
(
    input wire logic sys_clk,
    input wire mem_bus_t bus,
    input wire logic [7:0] vec,
    input wire logic slow,
    output logic [7:0] din,
    output logic wait_n
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    logic ack_q = 1'b0;
    // acknowledge answered with the even vector or opcode set by the bench
    // idle bus flips each cycle so a late latch cannot catch a stale byte
    assign din = bus.io_ack ? vec : (bus.mem_req && bus.rd) ? mem[bus.addr] : ~last;
    // slow mode adds one wait state to each acknowledge cycle
    // pulsed at its first strobed clock so it lands after the synchroniser in the last automatic wait
    assign wait_n = !(slow && bus.io_ack && !ack_q);
    always @(posedge sys_clk) begin
        last <= din;
        ack_q <= bus.io_ack;
        if (bus.mem_req && bus.wr)
            mem[bus.addr] <= bus.dout;
    end
endmodule // int_partner

/* verif/tb_cpu_interrupt_response.sv */
`timescale 1ns/1ns
`include "cpu_int_consts.svh"
module tb_cpu_interrupt_response import cpu_int_pkg::*;;
    logic sys_clk, rst, reg_wr, reg_rd, instr_done, instr_ei, instr_di, instr_return_from_nonmaskable, operand_req;
    logic busy, pc_load, sp_load, inject_valid, device_operands, nmi_n, int_n, slow, wait_n;
    logic accept_enable_flag, saved_enable_flag, busy_s;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, inject_byte, vec, din, rd_val, got_inj;
    logic [15:0] pc, sp, pc_value, sp_value, got_pc, got_sp, bcnt;
    pin_in_t pins;
    mem_bus_t bus;
    int fails, total_checks;
    assign pins = {nmi_n, int_n, wait_n, din};
    cpu_interrupt_response DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pins, .bus, .instr_done, .instr_ei, .instr_di, .instr_return_from_nonmaskable, .operand_req,
        .pc, .sp, .busy, .pc_load, .pc_value, .sp_load, .sp_value, .inject_valid, .inject_byte,
        .device_operands, .accept_enable_flag, .saved_enable_flag);
    int_partner u_partner (.sys_clk, .bus, .vec, .slow, .din, .wait_n);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // sampled mid-cycle so no edge race decides what is seen
    always @(negedge sys_clk) begin
        busy_s = busy;
        if (busy === 1'b1)
            bcnt = bcnt + 16'd1;
        if (pc_load === 1'b1)
            {got_pc, got_sp} = {pc_value, sp_value};
        if (inject_valid === 1'b1)
            got_inj = inject_byte;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = reg_rdata;
    endtask
    // three cycles flush the pin synchronisers
    task automatic set_req(input logic n, input logic i);
        @(posedge sys_clk);
        {nmi_n, int_n} <= {n, i};
        step(3);
    endtask
    task automatic boundary(input logic ei, input logic di, input logic rn);
        int i;
        @(posedge sys_clk);
        {instr_done, instr_ei, instr_di, instr_return_from_nonmaskable} <= {1'b1, ei, di, rn};
        {bcnt, got_pc} = 32'h0;
        @(posedge sys_clk);
        {instr_done, instr_ei, instr_di, instr_return_from_nonmaskable} <= 4'h0;
        for (i = 0; i < 300 && (i < 3 || busy_s === 1'b1); i++)
            @(posedge sys_clk);
        if (i == 300)
            fails++;
        if (i == 300)
            conclude();
        step(2);
        @(negedge sys_clk);
    endtask
    task automatic operand(input logic [7:0] b);
        vec <= b;
        @(posedge sys_clk);
        operand_req <= 1'b1;
        @(posedge sys_clk);
        operand_req <= 1'b0;
        step(12);
        @(negedge sys_clk);
        chk(got_inj, b);
    endtask
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, instr_done, instr_ei, instr_di, instr_return_from_nonmaskable, operand_req, slow} = 8'h00;
        {nmi_n, int_n, reg_addr, reg_wdata, vec} = {4'hc, 8'h00, 8'h34};
        {pc, sp, bcnt} = {16'h5678, 16'h8000, 16'h0};
        fails = 0;
        total_checks = 0;
        u_partner.mem[16'h1234] = 8'hcd;
        u_partner.mem[16'h1235] = 8'hab;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        step(3);
        rd(`REG_CTRL);
        chk(rd_val[1:0], 2'h0);
        rd(`REG_VPAGE);
        chk(rd_val, 8'h00);
        rd(`REG_REFRESH);
        chk(rd_val, 8'h00);
        wr(`REG_CTRL, 8'h03);
        rd(`REG_CTRL);
        chk(rd_val[1:0], 2'h0);
        wr(`REG_CTRL, 8'h02);
        wr(`REG_VPAGE, 8'h12);
        rd(`REG_CTRL);
        chk(rd_val[1:0], 2'h2);
        boundary(1'b1, 1'b0, 1'b0);
        set_req(1'b1, 1'b0);
        boundary(1'b1, 1'b0, 1'b0);
        chk(bcnt, 16'd0);
        boundary(1'b0, 1'b0, 1'b0);
        chk(got_pc, 16'habcd);
        chk(bcnt, 16'd19);
        chk(u_partner.mem[16'h7fff], 8'h56);
        chk(u_partner.mem[16'h7ffe], 8'h78);
        chk({accept_enable_flag, saved_enable_flag}, 2'b00);
        rd(`REG_STATUS);
        chk(rd_val, 8'h02);
        wr(`REG_CTRL, 8'h01);
        boundary(1'b1, 1'b0, 1'b0);
        boundary(1'b0, 1'b0, 1'b0);
        chk(got_pc, 16'h0038);
        chk(bcnt, 16'd13);
        set_req(1'b1, 1'b1);
        for (int e = 0; e < 2; e++) begin
            boundary(e[0], !e[0], 1'b0);
            set_req(1'b0, !e[0]);
            set_req(1'b1, !e[0]);
            boundary(1'b0, 1'b0, 1'b0);
            chk(got_pc, 16'h0066);
            chk(bcnt, 16'd11);
            chk({accept_enable_flag, saved_enable_flag}, {1'b0, e[0]});
            set_req(1'b1, 1'b1);
            boundary(1'b0, 1'b0, 1'b1);
            chk(accept_enable_flag, e[0]);
        end
        wr(`REG_CTRL, 8'h00);
        boundary(1'b1, 1'b0, 1'b0);
        vec = 8'hcd;
        set_req(1'b1, 1'b0);
        boundary(1'b0, 1'b0, 1'b0);
        chk(got_inj, 8'hcd);
        chk(device_operands, 1'b1);
        set_req(1'b1, 1'b1);
        for (int k = 1; k < 3; k++)
            operand({k[3:0], k[3:0]});
        // slow acknowledge: the answer must not change, only its length
        wr(`REG_CTRL, 8'h01);
        slow <= 1'b1;
        boundary(1'b1, 1'b0, 1'b0);
        set_req(1'b1, 1'b0);
        boundary(1'b0, 1'b0, 1'b0);
        chk(got_pc, 16'h0038);
        chk(bcnt, 16'd14);
        conclude();
    end
endmodule // tb_cpu_interrupt_response
